// *** gpt_consts.svh ***
// Constants of the timer, free-running counter and half-word order block.
// Assumes byte offsets on a 16-bit host bus whose A[1] picks the half-word.
`ifndef GPT_CONSTS_SVH
`define GPT_CONSTS_SVH
`define GPT_OFS_CFG        8'h8C
`define GPT_OFS_CNT        8'h90
`define GPT_OFS_SWAP       8'h98
`define GPT_OFS_FREE       8'h9C
`define GPT_EN_BIT         29
`define GPT_PRELOAD_MSB    15
`define GPT_PRELOAD_RST    16'hFFFF
`define GPT_COUNT_RST      16'hFFFF
`define GPT_SWAP_RST       32'h0000_0000
`define GPT_SWAP_REVERSE   32'hFFFF_FFFF
`define GPT_CLK_NS         10
`define GPT_SLOW_NS        40
`define GPT_FREE_CLR_NS    160
`define GPT_SLOW_DIV       (`GPT_SLOW_NS / `GPT_CLK_NS)
`define GPT_FREE_CLR_CYC   ((`GPT_FREE_CLR_NS + `GPT_CLK_NS - 1) / `GPT_CLK_NS)
`define GPT_PRESCALE_DEF   2500
`endif

// *** gpt_pkg.sv ***
// Types shared by the timer block files.
// Assumes gpt_consts.svh holds every number.
package gpt_pkg;
    typedef enum logic {GPT_HALT, GPT_RUN} gpt_state_type;
endpackage

// *** gpt_free_run.sv ***
// Free-running 32-bit counter advanced by a 25 MHz enable from a divider.
// Assumes one 100 MHz clock; it has no power-state input, so it never stops.
`timescale 1ns/1ps
`include "gpt_consts.svh"
module gpt_free_run #(
    parameter int DIV = `GPT_SLOW_DIV
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Count and slow enable
    output logic [31:0]      count_r,
    output logic             tick_r
);
    localparam int CLR_CYC = `GPT_FREE_CLR_CYC;
    logic [7:0] div_r;
    logic [7:0] clr_r;
    wire        div_end = (div_r == 8'(DIV - 1));
    wire        settled = (clr_r == 8'(CLR_CYC));

    if (DIV < 1 || DIV > 255) begin : g_chk
        $error("divider out of range");
    end

    // Divider makes one-cycle 25 MHz enable
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_r  <= 8'h00;
            tick_r <= 1'b0;
        end else begin
            div_r  <= div_end ? 8'h00 : div_r + 8'h01;
            tick_r <= div_end;
        end
    end

    // Clear settling window after reset, then count and wrap
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            clr_r   <= 8'h00;
            count_r <= 32'h0000_0000;
        end else if (!settled) begin
            clr_r   <= clr_r + 8'h01;                      // [R12]
            count_r <= 32'h0000_0000;
        end else if (tick_r) begin
            count_r <= count_r + 32'h0000_0001;             // [R9] [R10] [R13]
        end
    end

    a_free_wrap: assert property (@(posedge clk) disable iff (!rst_n) // [R10]
        tick_r && settled && count_r == 32'hFFFF_FFFF |=> count_r == 32'h0000_0000)
        else $error("free counter did not wrap");
    a_free_step: assert property (@(posedge clk) disable iff (!rst_n) // [R9]
        settled && !tick_r |=> $stable(count_r))
        else $error("free counter moved without tick");
    c_free_wrap: cover property (@(posedge clk) disable iff (!rst_n)
        tick_r && count_r == 32'hFFFF_FFFF);
endmodule // gpt_free_run

// *** gpt_timer_top.sv ***
// General purpose timer, free-running counter and half-word order registers.
// Assumes a synchronous 16-bit SRAM-like host bus; strobes are active low.
//
// Operation
// R1 - Setting the run enable bit runs the timer and clearing it halts it.
// R2 - A one-to-zero change of the run enable bit forces the preload to all ones.
// R3 - The preload is a 16-bit read/write field in bits 15-0, reset to all ones.
// R4 - The timer raises a periodic event with an interval set by the preload.
// R5 - The current count reads in bits 15-0, all ones after reset, upper bits zero.
// R6 - For any order value but all ones, A[1] high selects the upper half-word.
// R7 - With the order register all ones, A[1] high selects the lower half-word.
// R8 - Network-side FIFO order is always low half first, whatever the order value; here half_reverse_r follows the order value.
// R9 - The 32-bit free counter starts at zero and steps once per 25 MHz cycle.
// R10 - The free counter wraps to zero after its maximum and keeps counting.
// R11 - The first half-word read of the free counter latches all 32 bits.
// R12 - The free counter may take up to 160 ns after reset to read zero.
// R13 - The free counter runs in every power state.
// R14 - While running the timer decrements per tick and reloads past zero with an event.
// R15 - The host reads both free counter halves back to back to get one value.
`timescale 1ns/1ps
`include "gpt_consts.svh"
module gpt_timer_top #(
    parameter int PRESCALE = `GPT_PRESCALE_DEF
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Host bus
    input  wire logic        cs_n,
    input  wire logic        rd_n,
    input  wire logic        wr_n,
    input  wire logic [7:1]  addr,
    input  wire logic [15:0] data_in,
    output logic [15:0]      data_out_r,
    output logic             data_oe_r,
    // Block outputs
    output logic             timer_event_r,
    output logic             half_reverse_r
);
    // Register state
    logic                    run_en_r;
    logic [15:0]             timer_preload_value_r;
    logic [15:0]             timer_present_count_r;
    logic [31:0]             swap_r;
    logic [31:0]             free_latch_r;
    logic                    free_pend_r;
    logic                    rd_prev_r;
    logic                    wr_prev_r;
    logic [15:0]             pre_r;
    gpt_pkg::gpt_state_type  state_r;
    logic [31:0]             free_count;
    logic                    slow_tick;

    if (PRESCALE < 1 || PRESCALE > 65535) begin : g_chk
        $error("prescale out of range");
    end

    gpt_free_run u_free (
        .clk     (clk),
        .rst_n   (rst_n),
        .count_r (free_count),
        .tick_r  (slow_tick)
    );

    // Strobe decode and half-word selection
    wire        rd_act   = !cs_n && !rd_n;
    wire        wr_act   = !cs_n && !wr_n;
    wire        rd_start = rd_act && !rd_prev_r;
    wire        wr_start = wr_act && !wr_prev_r;
    wire [7:0]  byte_ofs = {addr[7:2], 2'b00};
    wire        reverse  = (swap_r == `GPT_SWAP_REVERSE);     // [R7]
    wire        hi_sel   = addr[1] ^ reverse;                 // [R6] [R7]
    wire        sel_cfg  = (byte_ofs == `GPT_OFS_CFG);
    wire        sel_cnt  = (byte_ofs == `GPT_OFS_CNT);
    wire        sel_swap = (byte_ofs == `GPT_OFS_SWAP);
    wire        sel_free = (byte_ofs == `GPT_OFS_FREE);
    wire        wr_cfg   = wr_start && sel_cfg;
    wire        wr_swap  = wr_start && sel_swap;
    wire        rd_free  = rd_start && sel_free;

    // Timer control
    wire        run_nxt  = (wr_cfg && hi_sel) ? data_in[`GPT_EN_BIT - 16] : run_en_r;
    wire        halt_evt = run_en_r && !run_nxt;
    wire        pre_end  = (pre_r == 16'(PRESCALE - 1));
    wire        tmr_tick = (state_r == gpt_pkg::GPT_RUN) && pre_end;
    wire        tmr_zero = (timer_present_count_r == 16'h0000);

    // Read data selection; reserved bits read zero
    wire [31:0] cfg_word  = {2'b00, run_en_r, 13'h0000, timer_preload_value_r};
    wire [31:0] cnt_word  = {16'h0000, timer_present_count_r};         // [R5]
    wire [31:0] free_word = free_pend_r ? free_latch_r : free_count;    // [R11]
    wire [31:0] rd_word   = sel_cfg  ? cfg_word  :
                            sel_cnt  ? cnt_word  :
                            sel_swap ? swap_r    :
                            sel_free ? free_word : 32'h0000_0000;
    wire [15:0] rd_half   = hi_sel ? rd_word[31:16] : rd_word[15:0];   // [R6] [R7]

    // Host strobe edges and read answer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_prev_r  <= 1'b0;
            wr_prev_r  <= 1'b0;
            data_out_r <= 16'h0000;
            data_oe_r  <= 1'b0;
        end else begin
            rd_prev_r  <= rd_act;
            wr_prev_r  <= wr_act;
            data_oe_r  <= rd_act;
            if (rd_start) begin
                data_out_r <= rd_half;
            end
        end
    end

    // Configuration writes; halting presets the preload
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            run_en_r              <= 1'b0;
            timer_preload_value_r <= `GPT_PRELOAD_RST;                   // [R3]
        end else begin
            run_en_r <= run_nxt;                                         // [R1]
            if (halt_evt) begin
                timer_preload_value_r <= `GPT_PRELOAD_RST;               // [R2]
            end else if (wr_cfg && !hi_sel) begin
                timer_preload_value_r <= data_in;                        // [R3]
            end
        end
    end

    // Order register; applies to host side, and half_reverse_r passes the same order to the network side
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            swap_r         <= `GPT_SWAP_RST;
            half_reverse_r <= 1'b0;
        end else begin
            if (wr_swap && hi_sel) begin
                swap_r[31:16] <= data_in;
            end else if (wr_swap) begin
                swap_r[15:0]  <= data_in;
            end
            half_reverse_r <= reverse;                                   // [R8]
        end
    end

    // Free counter latch: first half read captures, second uses the copy
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            free_latch_r <= 32'h0000_0000;
            free_pend_r  <= 1'b0;
        end else if (rd_free) begin
            if (!free_pend_r) begin
                free_latch_r <= free_count;                              // [R11] [R15]
            end
            free_pend_r <= !free_pend_r;
        end
    end

    // Timer state, prescaler and count
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r               <= gpt_pkg::GPT_HALT;
            pre_r                 <= 16'h0000;
            timer_present_count_r <= `GPT_COUNT_RST;                     // [R5]
            timer_event_r         <= 1'b0;
        end else begin
            timer_event_r <= 1'b0;
            case (state_r)
                gpt_pkg::GPT_HALT: begin
                    pre_r <= 16'h0000;
                    if (run_nxt) begin
                        state_r               <= gpt_pkg::GPT_RUN;       // [R1]
                        timer_present_count_r <= timer_preload_value_r;  // [R3]
                    end
                end
                gpt_pkg::GPT_RUN: begin
                    pre_r <= pre_end ? 16'h0000 : pre_r + 16'h0001;
                    if (!run_nxt) begin
                        state_r <= gpt_pkg::GPT_HALT;                    // [R1]
                    end else if (tmr_tick && tmr_zero) begin
                        timer_present_count_r <= timer_preload_value_r;  // [R14]
                        timer_event_r         <= 1'b1;                   // [R4]
                    end else if (tmr_tick) begin
                        timer_present_count_r <= timer_present_count_r - 16'h0001;
                    end
                end
                default: state_r <= gpt_pkg::GPT_HALT;
            endcase
        end
    end

    // Checks
    a_halt_preset: assert property (@(posedge clk) disable iff (!rst_n) // [R2]
        $fell(run_en_r) |-> timer_preload_value_r == `GPT_PRELOAD_RST)
        else $error("preload not preset on halt");
    a_halt_frozen: assert property (@(posedge clk) disable iff (!rst_n) // [R1]
        state_r == gpt_pkg::GPT_HALT && !run_nxt |=> $stable(timer_present_count_r))
        else $error("halted timer changed");
    a_count_step: assert property (@(posedge clk) disable iff (!rst_n) // [R14]
        tmr_tick && !tmr_zero && run_nxt |=>
        timer_present_count_r == $past(timer_present_count_r) - 16'h0001)
        else $error("timer did not decrement");
    a_reload_event: assert property (@(posedge clk) disable iff (!rst_n) // [R4]
        tmr_tick && tmr_zero && run_nxt |=>
        timer_event_r && timer_present_count_r == $past(timer_preload_value_r))
        else $error("no reload with event");
    a_event_cause: assert property (@(posedge clk) disable iff (!rst_n) // [R14]
        timer_event_r |-> $past(tmr_zero) && $past(state_r) == gpt_pkg::GPT_RUN)
        else $error("event without zero");
    a_half_normal: assert property (@(posedge clk) disable iff (!rst_n) // [R6]
        rd_start && sel_cnt && !reverse && addr[1] |=> data_out_r == 16'h0000)
        else $error("upper half of count not zero");
    a_half_reverse: assert property (@(posedge clk) disable iff (!rst_n) // [R7]
        rd_start && sel_cnt && reverse && addr[1] |=>
        data_out_r == $past(timer_present_count_r))
        else $error("reversed order not applied");
    a_free_latch: assert property (@(posedge clk) disable iff (!rst_n) // [R11]
        rd_free && !free_pend_r |=> free_pend_r && free_latch_r == $past(free_count))
        else $error("free counter not latched");
    // Second read of a pair must leave the captured copy alone
    a_free_keep: assert property (@(posedge clk) disable iff (!rst_n) // [R11]
        rd_free && free_pend_r |=> $stable(free_latch_r))
        else $error("free latch changed on second read");
    a_order_flag: assert property (@(posedge clk) disable iff (!rst_n) // [R8]
        half_reverse_r == $past(reverse))
        else $error("order flag does not follow register");
    c_timer_event: cover property (@(posedge clk) disable iff (!rst_n) timer_event_r);
    c_free_pair: cover property (@(posedge clk) disable iff (!rst_n)
        rd_free && free_pend_r);
    c_reverse_read: cover property (@(posedge clk) disable iff (!rst_n)
        rd_start && reverse);
    c_halt_preset: cover property (@(posedge clk) disable iff (!rst_n) $fell(run_en_r));
endmodule // gpt_timer_top

// *** gpt_host_model.sv ***
// Host model: a 16-bit SRAM-like bus master for the timer block.
// Assumes the bench calls rd and wr; bus lines change on the falling edge.
`timescale 1ns/1ps
module gpt_host_model (
    // Clock and read answer
    input  wire logic        clk,
    input  wire logic        data_oe_r,
    // Host bus
    output logic             cs_n,
    output logic             rd_n,
    output logic             wr_n,
    output logic [7:1]       addr,
    output logic [15:0]      data_in
);
    // Release the bus; released data lines show the inverse of the last value
    task automatic idle();
        cs_n    = 1'b1;
        rd_n    = 1'b1;
        wr_n    = 1'b1;
        data_in = ~data_in;
    endtask

    // Bus at rest from time zero
    initial begin
        addr    = 7'h00;
        data_in = 16'h0000;
        idle();
    end

    // One half-word write, strobe held over one start edge
    task automatic wr(input logic [7:0] ofs, input logic [15:0] d);
        @(negedge clk);
        addr    = ofs[7:1];
        data_in = d;
        cs_n    = 1'b0;
        wr_n    = 1'b0;
        @(negedge clk);
        idle();
    endtask

    // One half-word read, strobe held until the output enable answers
    task automatic rd(input logic [7:0] ofs);
        int n;
        @(negedge clk);
        addr = ofs[7:1];
        cs_n = 1'b0;
        rd_n = 1'b0;
        for (n = 0; n < 8 && data_oe_r !== 1'b1; n++)
            @(negedge clk);
        idle();
        @(negedge clk);
    endtask
endmodule // gpt_host_model

// *** gp_timer_freerun_word_swap_tb.sv ***
// Bench of the timer block: host model drives, a monitor checks each read whose note is not marked any value.
// Assumes gpt_timer_top and gpt_host_model; timer prescale shortened to 3.
`timescale 1ns/1ps
`include "gpt_consts.svh"
module gp_timer_freerun_word_swap_tb;
    localparam int PRE = 3;
    logic        clk, rst_n, cs_n, rd_n, wr_n, data_oe_r, oe_prev;
    logic        timer_event_r, half_reverse_r;
    logic [7:1]  addr;
    logic [15:0] data_in, data_out_r, last_rd, pre;
    logic [16:0] exp_q[$];
    logic [31:0] v1, v2;
    int          num_errors, compares, cyc, t0, n;

    gpt_timer_top #(.PRESCALE(PRE)) dut (.clk(clk), .rst_n(rst_n), .cs_n(cs_n),
        .rd_n(rd_n), .wr_n(wr_n), .addr(addr), .data_in(data_in),
        .data_out_r(data_out_r), .data_oe_r(data_oe_r),
        .timer_event_r(timer_event_r), .half_reverse_r(half_reverse_r));
    gpt_host_model host (.clk(clk), .data_oe_r(data_oe_r), .cs_n(cs_n),
        .rd_n(rd_n), .wr_n(wr_n), .addr(addr), .data_in(data_in));

    // Clock and cycle count with hang limit
    initial clk = 1'b0;
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            close_out();
        end
    end

    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask

    // Monitor: each new read answer meets the oldest note; bit 16 means any value
    always @(negedge clk) begin
        oe_prev <= data_oe_r;
        if (data_oe_r === 1'b1 && oe_prev !== 1'b1) begin
            last_rd = data_out_r;
            if (exp_q.size() == 0)
                check("spare read", 32'h1, 32'h0);
            else if (exp_q[0][16] === 1'b0)
                check("read data", {16'h0, data_out_r}, {16'h0, exp_q[0][15:0]});
            if (exp_q.size() != 0)
                void'(exp_q.pop_front());
        end
    end

    task automatic rd(input logic [7:0] ofs, input logic [16:0] e);
        exp_q.push_back(e);
        host.rd(ofs);
    endtask

    // Counts falling edges until the next timer event, at most 200
    task automatic wait_event(output int c);
        for (c = 1; c < 200 && timer_event_r !== 1'b1; c++)
            @(negedge clk);
    endtask

    task automatic close_out();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Main sequence
    initial begin
        rst_n = 1'b0;
        cyc = 0;
        num_errors = 0;
        compares = 0;
        n = $urandom(32'h6FAE);
        repeat (4) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        rd(`GPT_OFS_FREE, 17'h00000);
        rd(`GPT_OFS_FREE + 8'h02, 17'h00000);
        rd(`GPT_OFS_CFG, 17'h0FFFF);
        rd(`GPT_OFS_CFG + 8'h02, 17'h00000);
        rd(`GPT_OFS_CNT, 17'h0FFFF);
        rd(`GPT_OFS_CNT + 8'h02, 17'h00000);
        rd(`GPT_OFS_SWAP, 17'h00000);
        rd(8'hA0, 17'h00000);
        host.wr(`GPT_OFS_CNT, 16'h1234);
        rd(`GPT_OFS_CNT, 17'h0FFFF);
        // Random preload, run, and measure the event period
        pre = 16'($urandom_range(9, 3));
        host.wr(`GPT_OFS_CFG, pre);
        rd(`GPT_OFS_CFG, {1'b0, pre});
        host.wr(`GPT_OFS_CFG + 8'h02, 16'h2000);
        wait_event(n);
        @(negedge clk);
        wait_event(n);
        check("event interval", n, (pre + 1) * PRE);
        // Halt: preload preset, count frozen, no events
        host.wr(`GPT_OFS_CFG + 8'h02, 16'h0000);
        rd(`GPT_OFS_CFG, 17'h0FFFF);
        rd(`GPT_OFS_CNT, 17'h10000);
        v1[15:0] = last_rd;
        wait_event(n);
        check("halted events", n, 200);
        rd(`GPT_OFS_CNT, 17'h10000);
        check("frozen count", last_rd, v1[15:0]);
        // Half-word order reversal and return
        host.wr(`GPT_OFS_SWAP, 16'hFFFF);
        rd(`GPT_OFS_SWAP + 8'h02, 17'h00000);
        host.wr(`GPT_OFS_SWAP + 8'h02, 16'hFFFF);
        repeat (2) @(negedge clk);
        check("reverse flag", half_reverse_r, 1);
        rd(`GPT_OFS_CFG, 17'h00000);
        rd(`GPT_OFS_CFG + 8'h02, 17'h0FFFF);
        rd(`GPT_OFS_CNT + 8'h02, {1'b0, v1[15:0]});
        host.wr(`GPT_OFS_SWAP, 16'h0000);
        repeat (2) @(negedge clk);
        check("normal flag", half_reverse_r, 0);
        rd(`GPT_OFS_CFG + 8'h02, 17'h00000);
        // Free counter: upper half first latches, lower read later is coherent
        rd(`GPT_OFS_FREE + 8'h02, 17'h10000);
        v1[31:16] = last_rd;
        t0 = cyc;
        repeat (100) @(negedge clk);
        rd(`GPT_OFS_FREE, 17'h10000);
        v1[15:0] = last_rd;
        rd(`GPT_OFS_FREE, 17'h10000);
        v2[15:0] = last_rd;
        t0 = cyc - t0;
        rd(`GPT_OFS_FREE + 8'h02, 17'h10000);
        v2[31:16] = last_rd;
        n = int'(v2 - v1) - t0 / 4;
        check("free step", (n >= -1 && n <= 1), 1);
        check("unanswered reads", exp_q.size(), 0);
        close_out();
    end
endmodule // gp_timer_freerun_word_swap_tb
